// File: src/time_of_year_clock_pkg.sv
/*
  Constants and carrier types for the time-of-year clock register block.
  Assumes a 50 MHz system clock and a byte-wide register port on the local bus.
*/
package time_of_year_clock_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_HZ = 100;
  localparam int SQW_HZ = 1024;
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int SQW_HALF_CYC = CLK_HZ / (2 * SQW_HZ);

  localparam logic [15:0] OFS_HUND = 16'h8000;
  localparam logic [15:0] OFS_SEC = 16'h8001;
  localparam logic [15:0] OFS_MIN = 16'h8002;
  localparam logic [15:0] OFS_HOUR = 16'h8004;
  localparam logic [15:0] OFS_WDAY = 16'h8006;
  localparam logic [15:0] OFS_DATE = 16'h8008;
  localparam logic [15:0] OFS_MONTH = 16'h8009;
  localparam logic [15:0] OFS_YEAR = 16'h800A;
  localparam logic [15:0] OFS_CMD = 16'h800B;
  localparam logic [15:0] OFS_HB_CLR = 16'h080C;
  localparam logic [127:0] TIME_OFS = {OFS_YEAR, OFS_MONTH, OFS_DATE, OFS_WDAY,
                                       OFS_HOUR, OFS_MIN, OFS_SEC, OFS_HUND};

  localparam int IDX_HUND = 0;
  localparam int IDX_SEC = 1;
  localparam int IDX_MIN = 2;
  localparam int IDX_HOUR = 3;
  localparam int IDX_WDAY = 4;
  localparam int IDX_DATE = 5;
  localparam int IDX_MONTH = 6;
  localparam int IDX_YEAR = 7;

  localparam int HR_12H_BIT = 6;
  localparam int HR_PM_BIT = 5;
  localparam int MON_SQW_OFF_BIT = 6;
  localparam int MON_OSC_STOP_BIT = 7;
  localparam logic [7:0] MON_MASK = 8'h1F;
  localparam logic [7:0] CMD_MASK = 8'hFA;

  localparam logic [63:0] TIME_RST = 64'h0001010100000000;
  localparam logic [7:0] CMD_RST = 8'h80;
  localparam logic OSC_STOP_RST = 1'b1;
  localparam logic SQW_OFF_RST = 1'b1;

  localparam logic [7:0] HUND_MAX = 8'h99;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [5:0] HR24_MAX = 6'h23;
  localparam logic [4:0] HR12_MAX = 5'h12;
  localparam logic [4:0] HR12_PRE = 5'h11;
  localparam logic [4:0] HR12_MIN = 5'h01;
  localparam logic [7:0] WDAY_MAX = 8'h07;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] DAY_ONE = 8'h01;
  localparam logic [7:0] FEB = 8'h02;
  localparam logic [7:0] LAST_31 = 8'h31;
  localparam logic [7:0] LAST_30 = 8'h30;
  localparam logic [7:0] LAST_29 = 8'h29;
  localparam logic [7:0] LAST_28 = 8'h28;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic xfer_en;
    logic wd_int_sel;
    logic wd_assert;
    logic pulse_level;
    logic wd_enable;
    logic unused2;
    logic wd_flag;
    logic unused0;
  } clock_cmd_t;

endpackage : time_of_year_clock_pkg

// File: src/time_of_year_clock_regs.sv
/*
  Time-of-year clock register block: eight BCD timekeeping bytes with
  frozen readable copies, command register, square wave and heartbeat flag.
  Assumes single-cycle rd/wr strobes from logic on clk; timebase derived from clk.
*/
`timescale 1ns/1ps
module time_of_year_clock_regs
  import time_of_year_clock_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned SQW_HALF_CYCLES = SQW_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire reg_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic sqw_out,
  output logic hb_irq,
  output clock_cmd_t wd_ctrl
);

  logic [7:0] tm_int [8];
  logic [7:0] tm_usr [8];
  logic [7:0] next_tm [8];
  logic [7:0] rd_chain [9];
  logic [7:0] hit;
  logic [7:0] wr_hit;
  logic [7:0] load;
  logic [7:0] dirty;
  clock_cmd_t cmd;
  logic osc_stop;
  logic sqw_off;
  logic [19:0] tick_cnt;
  logic [15:0] sqw_cnt;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // bus decode
  wire cmd_hit = req.addr == OFS_CMD;
  wire cmd_wr = req.wr && cmd_hit;
  wire hb_clr = req.wr && (req.addr == OFS_HB_CLR);
  wire te_rise = cmd_wr && req.wdata[7] && !cmd.xfer_en;
  wire [7:0] cmd_rd = cmd & CMD_MASK;

  // timebase
  wire tick_end = tick_cnt == 20'(TICK_CYCLES - 1);
  wire adv = !osc_stop && tick_end;
  wire sqw_run = !osc_stop && !sqw_off;
  wire sqw_tog = sqw_run && (sqw_cnt == 16'(SQW_HALF_CYCLES - 1));
  wire sqw_rise = sqw_tog && !sqw_out;

  // carry chain
  wire [7:0] hr = tm_int[IDX_HOUR];
  wire hr12 = hr[HR_12H_BIT];
  wire [7:0] hr_inc = bcd_inc({2'b00, hr12 ? {1'b0, hr[4:0]} : hr[5:0]});
  wire c_sec = adv && tm_int[IDX_HUND] == HUND_MAX;
  wire c_min = c_sec && tm_int[IDX_SEC] == SEC_MAX;
  wire c_hr = c_min && tm_int[IDX_MIN] == SEC_MAX;
  wire day_end = hr12 ? (hr[HR_PM_BIT] && hr[4:0] == HR12_PRE) : (hr[5:0] == HR24_MAX);
  wire c_day = c_hr && day_end;

  // month length; leap test is (2*tens + units) mod 4 on the BCD year
  wire [7:0] mon = tm_int[IDX_MONTH];
  wire [7:0] yr = tm_int[IDX_YEAR];
  wire [1:0] yr_mod4 = 2'({yr[4], 1'b0} + yr[1:0]);
  wire short_mon = (mon == 8'h04) || (mon == 8'h06) || (mon == 8'h09) || (mon == 8'h11);
  wire [7:0] feb_last = (yr_mod4 == 2'b00) ? LAST_29 : LAST_28;
  wire [7:0] last_day = (mon == FEB) ? feb_last : (short_mon ? LAST_30 : LAST_31);
  wire c_mon = c_day && tm_int[IDX_DATE] == last_day;
  wire c_yr = c_mon && mon == MONTH_MAX;

  logic [7:0] hr_next;

  always_comb begin
    hr_next = hr;
    if (!hr12) begin
      hr_next = (hr[5:0] == HR24_MAX) ? {hr[7:6], 6'h00} : {hr[7:6], hr_inc[5:0]};
    end else if (hr[4:0] == HR12_MAX) begin
      hr_next = {hr[7:5], HR12_MIN};
    end else if (hr[4:0] == HR12_PRE) begin
      hr_next = {hr[7:6], ~hr[HR_PM_BIT], HR12_MAX};
    end else begin
      hr_next = {hr[7:5], hr_inc[4:0]};
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      next_tm[i] = tm_int[i];
    end
    if (adv) begin
      next_tm[IDX_HUND] = (tm_int[IDX_HUND] == HUND_MAX) ? 8'h00 : bcd_inc(tm_int[IDX_HUND]);
    end
    if (c_sec) begin
      next_tm[IDX_SEC] = (tm_int[IDX_SEC] == SEC_MAX) ? 8'h00 : bcd_inc(tm_int[IDX_SEC]);
    end
    if (c_min) begin
      next_tm[IDX_MIN] = (tm_int[IDX_MIN] == SEC_MAX) ? 8'h00 : bcd_inc(tm_int[IDX_MIN]);
    end
    if (c_hr) begin
      next_tm[IDX_HOUR] = hr_next;
    end
    if (c_day) begin
      next_tm[IDX_WDAY] = (tm_int[IDX_WDAY] == WDAY_MAX) ? DAY_ONE : bcd_inc(tm_int[IDX_WDAY]);
      next_tm[IDX_DATE] = (tm_int[IDX_DATE] == last_day) ? DAY_ONE : bcd_inc(tm_int[IDX_DATE]);
    end
    if (c_mon) begin
      next_tm[IDX_MONTH] = (mon == MONTH_MAX) ? DAY_ONE : bcd_inc(mon);
    end
    if (c_yr) begin
      next_tm[IDX_YEAR] = (yr == YEAR_MAX) ? 8'h00 : bcd_inc(yr);
    end
  end

  assign rd_chain[0] = cmd_hit ? cmd_rd : 8'h00;

  for (genvar i = 0; i < 8; i++) begin : g_byte
    // month control bits live outside the time byte so they act at once
    wire [7:0] wval = (i == IDX_MONTH) ? (req.wdata & MON_MASK) : req.wdata;
    wire [7:0] shown = (i == IDX_MONTH) ? {osc_stop, sqw_off, tm_usr[i][5:0]} : tm_usr[i];
    assign hit[i] = req.addr == TIME_OFS[16*i +: 16];
    assign wr_hit[i] = req.wr && hit[i];
    assign load[i] = te_rise && dirty[i];
    assign rd_chain[i+1] = rd_chain[i] | (hit[i] ? shown : 8'h00);

    always_ff @(posedge clk) begin
      if (reset) begin
        tm_int[i] <= TIME_RST[8*i +: 8];
        tm_usr[i] <= TIME_RST[8*i +: 8];
        dirty[i] <= 1'b0;
      end else begin
        if (wr_hit[i] && cmd.xfer_en) begin
          tm_int[i] <= wval;
        end else if (load[i]) begin
          tm_int[i] <= tm_usr[i];
        end else begin
          tm_int[i] <= next_tm[i];
        end
        if (wr_hit[i]) begin
          tm_usr[i] <= wval;
        end else if (cmd.xfer_en) begin
          tm_usr[i] <= next_tm[i];
        end
        dirty[i] <= (wr_hit[i] && !cmd.xfer_en) || (dirty[i] && !te_rise);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmd <= CMD_RST;
      osc_stop <= OSC_STOP_RST;
      sqw_off <= SQW_OFF_RST;
    end else begin
      if (cmd_wr) begin
        cmd <= req.wdata & CMD_MASK;
      end
      if (wr_hit[IDX_MONTH]) begin
        osc_stop <= req.wdata[MON_OSC_STOP_BIT];
        sqw_off <= req.wdata[MON_SQW_OFF_BIT];
      end
    end
  end

  // stopped oscillator clears the prescaler so a restart starts a full tick
  always_ff @(posedge clk) begin
    if (reset || osc_stop || tick_end) begin
      tick_cnt <= 20'h00000;
    end else begin
      tick_cnt <= tick_cnt + 20'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !sqw_run) begin
      sqw_cnt <= 16'h0000;
      sqw_out <= 1'b0;
    end else if (sqw_tog) begin
      sqw_cnt <= 16'h0000;
      sqw_out <= !sqw_out;
    end else begin
      sqw_cnt <= sqw_cnt + 16'h0001;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      hb_irq <= 1'b0;
    end else if (sqw_rise) begin
      hb_irq <= 1'b1;
    end else if (hb_clr) begin
      hb_irq <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= req.rd ? rd_chain[8] : 8'h00;
      rvalid <= req.rd;
    end
  end

  assign wd_ctrl = cmd;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);

  wire hr_step = c_hr && !wr_hit[IDX_HOUR] && !load[IDX_HOUR];

  chk_byte_write_back: assert property (
    wr_hit[IDX_SEC] |=> tm_usr[IDX_SEC] == $past(req.wdata))
    else $error("written second byte not held");

  chk_hour_24_wrap: assert property (
    (hr_step && !hr12 && hr[5:0] == HR24_MAX) |=> tm_int[IDX_HOUR][5:0] == 6'h00)
    else $error("24-hour wrap wrong");

  chk_hour_12_wrap: assert property (
    (hr_step && hr12 && hr[4:0] == HR12_MAX) |=> tm_int[IDX_HOUR][4:0] == HR12_MIN)
    else $error("12-hour wrap wrong");

  chk_pm_flag_toggle: assert property (
    (hr_step && hr12 && hr[4:0] == HR12_PRE) |=> tm_int[IDX_HOUR][HR_PM_BIT] != $past(hr[HR_PM_BIT]))
    else $error("AM/PM flag did not toggle");

  chk_sqw_disabled_low: assert property (
    sqw_off |=> !sqw_out)
    else $error("square wave runs while disabled");

  chk_osc_stop_hold: assert property (
    (osc_stop && !wr_hit[IDX_HUND] && !load[IDX_HUND]) |=> $stable(tm_int[IDX_HUND]))
    else $error("time advanced with oscillator stopped");

  chk_frozen_read: assert property (
    (!cmd.xfer_en && !wr_hit[IDX_SEC]) |=> $stable(tm_usr[IDX_SEC]))
    else $error("frozen value changed");

  chk_cmd_unused_zero: assert property (
    (req.rd && cmd_hit) |=> rvalid && rdata[0] == 1'b0 && rdata[2] == 1'b0)
    else $error("unused command bits read nonzero");

  chk_heartbeat_set: assert property (
    $rose(sqw_out) |-> hb_irq)
    else $error("heartbeat not set on rising edge");

  chk_heartbeat_sticky: assert property (
    (hb_irq && !hb_clr) |=> hb_irq)
    else $error("heartbeat lost without clear write");

  chk_heartbeat_clear: assert property (
    (hb_clr && !sqw_rise) |=> !hb_irq)
    else $error("heartbeat not cleared by write");

  chk_second_carry: assert property (
    (c_min && !wr_hit[IDX_SEC] && !load[IDX_SEC]) |=> tm_int[IDX_SEC] == 8'h00)
    else $error("second rollover wrong");

  chk_deferred_load: assert property (
    load[IDX_SEC] |=> tm_int[IDX_SEC] == $past(tm_usr[IDX_SEC]))
    else $error("pending second byte not loaded");

  chk_osc_stop_quiet: assert property (
    osc_stop |=> !sqw_out)
    else $error("square wave runs with oscillator stopped");

  chk_cmd_store: assert property (
    cmd_wr |=> wd_ctrl == ($past(req.wdata) & CMD_MASK))
    else $error("command byte not stored");

  chk_heartbeat_source: assert property (
    sqw_rise |=> sqw_out && hb_irq)
    else $error("square wave rise did not reach heartbeat");

  chk_read_idle_zero: assert property (
    !req.rd |=> !rvalid && rdata == 8'h00)
    else $error("read port not idle");

  chk_unmapped_read: assert property (
    (req.rd && hit == 8'h00 && !cmd_hit) |=> rdata == 8'h00)
    else $error("unmapped offset read nonzero");

  cov_heartbeat: cover property ($rose(hb_irq) ##[1:4] hb_clr);
  cov_day_roll: cover property (c_day);
  cov_deferred_load: cover property (te_rise && dirty != 8'h00);
  cov_pm_roll: cover property (hr_step && hr12 && hr[4:0] == HR12_PRE);

endmodule : time_of_year_clock_regs

// File: testbench/time_of_year_clock_regs_bench.sv
/*
  Self-checking bench for the time-of-year clock register block.
  Assumes the block runs with shortened tick and square-wave counts.
*/
`timescale 1ns/1ps
module time_of_year_clock_regs_bench import time_of_year_clock_pkg::*;;
  localparam int TICK = 10;
  localparam int HALF = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid;
  logic sqw_out;
  logic hb_irq;
  clock_cmd_t wd_ctrl;
  int errors = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h0000000F;
  logic [15:0] a;
  logic [7:0] v;
  logic [7:0] w;
  int n;

  time_of_year_clock_regs #(.TICK_CYCLES(TICK), .SQW_HALF_CYCLES(HALF)) i_time_of_year_clock_regs (
    .clk(clk),
    .reset(reset),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid),
    .sqw_out(sqw_out),
    .hb_irq(hb_irq),
    .wd_ctrl(wd_ctrl)
  );

  always #10 clk = ~clk;

  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd8

  // month bit 5 is not stored, command bits 0 and 2 are unused
  function automatic logic [7:0] exp_reg(input logic [15:0] ad, input logic [7:0] d);
    if (ad == OFS_MONTH) return d & 8'hDF;
    if (ad == OFS_CMD) return d & CMD_MASK;
    return d;
  endfunction : exp_reg

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    @(negedge clk) req = '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
    @(negedge clk) req = '0;
  endtask : wr

  // answer stands one cycle, then the data port returns to zero
  task automatic rd(input logic [15:0] ad, output logic [7:0] d);
    @(negedge clk) req = '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    @(negedge clk) req = '0;
    check_bit(rvalid, 1'b1);
    d = rdata;
    @(negedge clk);
    check_bit(rvalid, 1'b0);
    check_byte(rdata, 8'h00);
  endtask : rd

  // ymd packs year, month and date as BCD bytes
  task automatic carry_case(input logic [7:0] h_in, input logic [7:0] h_exp, input logic [23:0] ymd_in,
    input logic [23:0] ymd_exp);
    wr(OFS_MONTH, 8'hC0 | ymd_in[15:8]);
    wr(OFS_HUND, 8'h99);
    wr(OFS_SEC, 8'h59);
    wr(OFS_MIN, 8'h59);
    wr(OFS_HOUR, h_in);
    wr(OFS_DATE, ymd_in[7:0]);
    wr(OFS_YEAR, ymd_in[23:16]);
    wr(OFS_MONTH, 8'h40 | ymd_in[15:8]);
    for (n = 0; n < 30; n++) begin
      rd(OFS_HUND, v);
      if (v !== 8'h99) break;
    end
    check_byte(v, 8'h00);
    // later ticks only touch hundredths, so the upper bytes are read while running
    rd(OFS_SEC, v);
    check_byte(v, 8'h00);
    rd(OFS_MIN, v);
    check_byte(v, 8'h00);
    rd(OFS_HOUR, v);
    check_byte(v, h_exp);
    rd(OFS_DATE, v);
    check_byte(v, ymd_exp[7:0]);
    rd(OFS_MONTH, v);
    check_byte(v, 8'h40 | ymd_exp[15:8]);
    rd(OFS_YEAR, v);
    check_byte(v, ymd_exp[23:16]);
    wr(OFS_MONTH, 8'hC0 | ymd_exp[15:8]);
  endtask : carry_case

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(TIME_OFS[i*16 +: 16], v);
      check_byte(v, (i == IDX_MONTH) ? 8'hC1 : TIME_RST[i*8 +: 8]);
    end
    rd(OFS_CMD, v);
    check_byte(v, CMD_RST);
    rd(16'h8003, v);
    check_byte(v, 8'h00);
    check_bit(hb_irq, 1'b0);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) begin
      a = TIME_OFS[i*16 +: 16];
      w = (i == IDX_MONTH) ? (rnd8() | 8'hC0) : rnd8();
      wr(a, w);
      rd(a, v);
      check_byte(v, exp_reg(a, w));
    end
    wr(16'h8005, rnd8());
    rd(16'h8005, v);
    check_byte(v, 8'h00);
    repeat (4) begin
      w = rnd8() | 8'h80;
      wr(OFS_CMD, w);
      rd(OFS_CMD, v);
      check_byte(v, exp_reg(OFS_CMD, w));
      check_byte(wd_ctrl, exp_reg(OFS_CMD, w));
    end
    wr(OFS_CMD, 8'h80);
    $display("test read_write done");
    carry_case(8'h23, 8'h00, 24'h000101, 24'h000102);
    carry_case(8'h51, 8'h72, 24'h000101, 24'h000101);
    carry_case(8'h71, 8'h52, 24'h000101, 24'h000102);
    carry_case(8'h72, 8'h61, 24'h000101, 24'h000101);
    carry_case(8'h23, 8'h00, 24'h040228, 24'h040229);
    carry_case(8'h23, 8'h00, 24'h010228, 24'h010301);
    carry_case(8'h23, 8'h00, 24'h120430, 24'h120501);
    carry_case(8'h23, 8'h00, 24'h991231, 24'h000101);
    $display("test hour_carry done");
    wr(OFS_MONTH, 8'h41);
    wr(OFS_CMD, 8'h00);
    rd(OFS_HUND, w);
    repeat (40) @(negedge clk);
    rd(OFS_HUND, v);
    check_byte(v, w);
    wr(OFS_SEC, 8'h33);
    repeat (40) @(negedge clk);
    rd(OFS_SEC, v);
    check_byte(v, 8'h33);
    wr(OFS_CMD, 8'h80);
    rd(OFS_SEC, v);
    check_byte(v, 8'h33);
    rd(OFS_HUND, v);
    check_bit(v !== w, 1'b1);
    $display("test freeze done");
    wr(OFS_MONTH, 8'hC1);
    wr(OFS_HB_CLR, 8'h00);
    check_bit(hb_irq, 1'b0);
    wr(OFS_MONTH, 8'h01);
    for (n = 0; n < 40 && sqw_out !== 1'b1; n++) @(negedge clk);
    check_bit(hb_irq, 1'b1);
    for (n = 0; n < 20 && sqw_out === 1'b1; n++) @(negedge clk);
    check_byte(n[7:0], HALF[7:0]);
    wr(OFS_MONTH, 8'h41);
    repeat (20) @(negedge clk);
    check_bit(sqw_out, 1'b0);
    check_bit(hb_irq, 1'b1);
    rd(OFS_HB_CLR, v);
    check_byte(v, 8'h00);
    check_bit(hb_irq, 1'b1);
    wr(OFS_HB_CLR, rnd8());
    check_bit(hb_irq, 1'b0);
    $display("test heartbeat done");
    tally_and_finish();
  end
endmodule : time_of_year_clock_regs_bench
